// [sps_modem.sv]
`timescale 1ns/1ns
module sps_modem (
   input wire logic clk_i,
   input wire logic [3:0] tgl_i,
   output logic [3:0] modem_o
);
   // modem lines idle low; toggles land away from the block's sync stages
   initial modem_o = 4'h0;
   always @(posedge clk_i) modem_o <= #2 modem_o ^ tgl_i;
endmodule

// [sps_pkg.sv]
package sps_pkg;
   localparam int ADDR_W = 8;
   // register byte addresses
   localparam logic [7:0] IER_ADDR = 8'h08;
   localparam logic [7:0] IDR_ADDR = 8'h0C;
   localparam logic [7:0] IMR_ADDR = 8'h10;
   localparam logic [7:0] CSR_ADDR = 8'h14;
   localparam logic [7:0] CR_ADDR = 8'h00;
   // status and mask bit positions
   localparam int B_RECEIVE_CHAR_READY = 0;
   localparam int B_TRANSMIT_HOLDING_FREE = 1;
   localparam int B_LINE_BREAK_SEEN = 2;
   localparam int B_RECEIVE_DMA_DONE = 3;
   localparam int B_TRANSMIT_DMA_DONE = 4;
   localparam int B_OVERRUN_FLAG = 5;
   localparam int B_FRAME = 6;
   localparam int B_PARITY_FAULT_FLAG = 7;
   localparam int B_TOUT = 8;
   localparam int B_TRANSMITTER_DRAINED = 9;
   localparam int B_ITER = 10;
   localparam int B_TRANSMIT_DMA_BUFFER_EMPTY = 11;
   localparam int B_RECEIVE_DMA_BUFFER_FULL = 12;
   localparam int B_NACK = 13;
   localparam int B_CHG_LO = 16;
   localparam int B_MASK_MAN = 20;
   localparam int B_IMG_LO = 20;
   localparam int B_CSR_MAN = 24;
   // valid mask bits: 0..13 and 16..20
   localparam logic [31:0] IMR_VALID = 32'h001F_3FFF;
   localparam logic [31:0] IMR_RESET = 32'h0000_0000;
   // command register bits
   localparam int C_CLEAR_STATUS_COMMAND = 8;
   localparam int C_RSTIT = 13;
   localparam int C_CLEAR_NONACK_COMMAND = 14;

   // events from the character engines, one-cycle pulses or levels
   typedef struct packed {
      logic char_done;
      logic rhr_read;
      logic rx_en;
      logic thr_full;
      logic shift_busy;
      logic brk_pending;
      logic tx_en;
      logic brk_evt;
      logic ovr_evt;
      logic frame_evt;
      logic par_evt;
      logic tout_evt;
      logic iter_evt;
      logic nack_evt;
      logic man_evt;
   } sps_engine_t;

   typedef struct packed {
      logic rx_end;
      logic tx_end;
      logic tx_bufe;
      logic rx_buff;
   } sps_dma_t;
endpackage

// [sps_status.sv]
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - read-only mask view, unlisted bits zero
// - status word with modem images and changes
// - receive ready set on char, cleared on read/disable
// - receive ready returns when receiver re-enabled
// - transmit ready low when holding full/break/disabled
// - sticky break flag, cleared by status command
// - sticky overrun, cleared by status command
// - sticky framing error, status command clears
// - sticky parity error, status command clears
// - time-out flag, held low when value zero
// - transmitter empty low while busy or disabled
// - sticky iteration, cleared by repetition command
// - sticky nack, cleared by nack command
// - live dma end signals shown
// - live dma buffer signals shown
// - modem change flags, cleared by status read
// - modem line levels shown after three-stage sync, once second and third stages agree
// - sticky manchester error, status command clears
// - enable write sets mask bits
// - disable write clears mask bits
module sps_status
   import sps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire sps_engine_t eng_i,
   input wire sps_dma_t dma_i,
   input wire logic tout_zero_i,
   input wire logic [3:0] modem_i,
   output logic irq_o
);
   logic [31:0] imr_reg;
   logic [31:0] rdata_reg;
   logic receive_char_ready_reg;
   logic rx_pend_reg;
   logic brk_reg;
   logic ovr_reg;
   logic frm_reg;
   logic par_reg;
   logic tout_reg;
   logic iter_reg;
   logic nack_reg;
   logic man_reg;
   logic [3:0] chg_reg;
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [3:0] s3_reg;
   logic [31:0] csr;
   logic cmd_wr;
   logic clear_status_command;
   logic csr_rd;
   logic transmit_holding_free;
   logic transmitter_drained;

   assign cmd_wr = wr_i && addr_i == CR_ADDR;
   assign clear_status_command = cmd_wr && wdata_i[C_CLEAR_STATUS_COMMAND];
   assign csr_rd = rd_i && addr_i == CSR_ADDR;

   function automatic logic sticky(input logic q, input logic set,
                                   input logic clr);
      // set beats clear so a same-cycle event is kept
      return set | (q & ~clr);
   endfunction

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         imr_reg <= IMR_RESET;
      end else if (wr_i && addr_i == IER_ADDR) begin
         imr_reg <= (imr_reg | wdata_i) & IMR_VALID;
      end else if (wr_i && addr_i == IDR_ADDR) begin
         imr_reg <= imr_reg & ~wdata_i;
      end
   end

   // a char seen while disabled is remembered for re-enable
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         receive_char_ready_reg <= 1'b0;
         rx_pend_reg <= 1'b0;
      end else if (!eng_i.rx_en) begin
         receive_char_ready_reg <= 1'b0;
         rx_pend_reg <= rx_pend_reg | eng_i.char_done | receive_char_ready_reg;
      end else begin
         receive_char_ready_reg <= eng_i.char_done | rx_pend_reg
                      | (receive_char_ready_reg & ~eng_i.rhr_read);
         rx_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         brk_reg <= 1'b0;
         ovr_reg <= 1'b0;
         frm_reg <= 1'b0;
         par_reg <= 1'b0;
         man_reg <= 1'b0;
      end else begin
         brk_reg <= sticky(brk_reg, eng_i.brk_evt, clear_status_command);
         ovr_reg <= sticky(ovr_reg, eng_i.ovr_evt, clear_status_command);
         frm_reg <= sticky(frm_reg, eng_i.frame_evt, clear_status_command);
         par_reg <= sticky(par_reg, eng_i.par_evt, clear_status_command);
         man_reg <= sticky(man_reg, eng_i.man_evt, clear_status_command);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tout_reg <= 1'b0;
      end else if (tout_zero_i) begin
         tout_reg <= 1'b0;
      end else begin
         tout_reg <= eng_i.tout_evt | tout_reg;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         iter_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else begin
         iter_reg <= sticky(iter_reg, eng_i.iter_evt,
                            cmd_wr && wdata_i[C_RSTIT]);
         nack_reg <= sticky(nack_reg, eng_i.nack_evt,
                            cmd_wr && wdata_i[C_CLEAR_NONACK_COMMAND]);
      end
   end

   // three-stage sync; second and third agree before use
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
      end else begin
         s1_reg <= modem_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   logic [3:0] img_reg;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         img_reg <= 4'h0;
         chg_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               img_reg[i] <= s3_reg[i];
            end
         end
         // change seen during the read still survives it
         chg_reg <= ((s2_reg ~^ s3_reg) & (s3_reg ^ img_reg))
                    | (chg_reg & {4{~csr_rd}});
      end
   end

   assign transmit_holding_free = eng_i.tx_en & ~eng_i.thr_full
                  & ~eng_i.brk_pending;
   assign transmitter_drained = eng_i.tx_en & ~eng_i.thr_full
                    & ~eng_i.shift_busy;

   always_comb begin
      csr = 32'h0000_0000;
      csr[B_RECEIVE_CHAR_READY] = receive_char_ready_reg;
      csr[B_TRANSMIT_HOLDING_FREE] = transmit_holding_free;
      csr[B_LINE_BREAK_SEEN] = brk_reg;
      csr[B_RECEIVE_DMA_DONE] = dma_i.rx_end;
      csr[B_TRANSMIT_DMA_DONE] = dma_i.tx_end;
      csr[B_OVERRUN_FLAG] = ovr_reg;
      csr[B_FRAME] = frm_reg;
      csr[B_PARITY_FAULT_FLAG] = par_reg;
      csr[B_TOUT] = tout_reg;
      csr[B_TRANSMITTER_DRAINED] = transmitter_drained;
      csr[B_ITER] = iter_reg;
      csr[B_TRANSMIT_DMA_BUFFER_EMPTY] = dma_i.tx_bufe;
      csr[B_RECEIVE_DMA_BUFFER_FULL] = dma_i.rx_buff;
      csr[B_NACK] = nack_reg;
      csr[B_CHG_LO +: 4] = chg_reg;
      csr[B_IMG_LO +: 4] = img_reg;
      csr[B_CSR_MAN] = man_reg;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            IMR_ADDR: rdata_reg <= imr_reg & IMR_VALID;
            CSR_ADDR: rdata_reg <= csr;
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   assign rdata_o = rdata_reg;

   // status bits 0..13 map to mask 0..13, change flags 16..19,
   // manchester error moves from status 24 to mask 20
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(imr_reg & {11'h000, csr[B_CSR_MAN],
                               csr[19:0]} & IMR_VALID);
      end
   end
endmodule

// [sps_status_chk.sv]
`timescale 1ns/1ns
module sps_status_chk
   import sps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire sps_engine_t eng_i,
   input wire sps_dma_t dma_i,
   input wire logic tout_zero_i,
   input wire logic [3:0] modem_i,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // no error event that could re-set the flag right after the command
   wire quiet = !(eng_i.ovr_evt | eng_i.frame_evt);
   sequence rd_csr; rd_i && addr_i == CSR_ADDR; endsequence
   sequence rd_imr; rd_i && addr_i == IMR_ADDR; endsequence
   sequence wr_at(a); wr_i && addr_i == a; endsequence
   rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not idle");
   mask_rsvd_a: assert property (rd_imr |=> !(rdata_o & ~IMR_VALID))
      else $error("reserved mask bits set");
   dma_end_a: assert property (rd_csr |=> rdata_o[4:3] ==
      {$past(dma_i.tx_end), $past(dma_i.rx_end)}) else $error("dma end");
   dma_buf_a: assert property (rd_csr |=> rdata_o[12:11] ==
      {$past(dma_i.rx_buff), $past(dma_i.tx_bufe)}) else $error("dma buf");
   tx_off_a: assert property (!eng_i.tx_en ##1 (!eng_i.tx_en and rd_csr)
      |=> !rdata_o[B_TRANSMIT_HOLDING_FREE] && !rdata_o[B_TRANSMITTER_DRAINED]) else $error("tx off");
   ier_set_a: assert property (wr_at(IER_ADDR) ##2 rd_imr
      |=> !(~rdata_o & $past(wdata_i, 3) & IMR_VALID)) else $error("ier");
   idr_clr_a: assert property (wr_at(IDR_ADDR) ##2 rd_imr
      |=> !(rdata_o & $past(wdata_i, 3))) else $error("idr");
   irq_off_a: assert property (wr_i && addr_i == IDR_ADDR &&
      wdata_i == 32'hFFFF_FFFF ##1 !wr_i |=> !irq_o) else $error("irq");
   sta_clr_a: assert property (wr_i && addr_i == CR_ADDR &&
      wdata_i[C_CLEAR_STATUS_COMMAND] && quiet ##1 quiet ##1 rd_csr
      |=> !rdata_o[B_OVERRUN_FLAG] && !rdata_o[B_FRAME]) else $error("clear_status_command");
endmodule
bind sps_status sps_status_chk i_chk (.*);

// [sps_status_tb.sv]
`timescale 1ns/1ns
module sps_status_tb
   import sps_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o, d;
   logic [14:0] base = 15'h1100;
   sps_engine_t eng_i = 15'h1100;
   sps_dma_t dma_i = 4'h0;
   logic tout_zero_i = 1'b0;
   logic [3:0] modem_i;
   logic [3:0] tgl = 4'h0;
   logic irq_o;
   int bad_count = 0;
   int checks_done = 0;
   // engine bit, status bit, command bit
   int rows [7][3] = '{'{7,2,8}, '{6,5,8}, '{5,6,8}, '{4,7,8},
      '{2,10,13}, '{1,13,14}, '{0,24,8}};
   logic [14:0] txe [4] = '{15'h1900, 15'h1500, 15'h1000, 15'h1100};
   logic [1:0] txo [4] = '{2'h0, 2'h1, 2'h0, 2'h3};
   always #5 clk_i = ~clk_i;
   sps_modem i_modem (.clk_i(clk_i), .tgl_i(tgl), .modem_o(modem_i));
   sps_status i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .eng_i(eng_i), .dma_i(dma_i), .tout_zero_i(tout_zero_i),
      .modem_i(modem_i), .irq_o(irq_o));
   task end_of_test;
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         $display("ERROR %0t got %h exp %h", $time, g, e);
         bad_count++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task pulse(input int b);
      @(posedge clk_i);
      eng_i <= base | (15'h1 << b);
      @(posedge clk_i);
      eng_i <= base;
   endtask
   initial begin
      #100000;
      bad_count++;
      end_of_test;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(IMR_ADDR);
      chk(d, IMR_RESET);
      wr(IER_ADDR, 32'hFFFF_FFFF);
      rd(IMR_ADDR);
      chk(d, IMR_VALID);
      chk(irq_o, 1);
      wr(IDR_ADDR, 32'h1);
      rd(IMR_ADDR);
      chk(d, IMR_VALID & ~32'h1);
      wr(IDR_ADDR, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 0);
      foreach (rows[i]) begin
         pulse(rows[i][0]);
         rd(CSR_ADDR);
         chk(d[rows[i][1]], 1);
         wr(CR_ADDR, 32'h1 << rows[i][2]);
         rd(CSR_ADDR);
         chk(d[rows[i][1]], 0);
      end
      pulse(3);
      rd(CSR_ADDR);
      chk(d[B_TOUT], 1);
      tout_zero_i <= 1'b1;
      rd(CSR_ADDR);
      chk(d[B_TOUT], 0);
      tout_zero_i <= 1'b0;
      pulse(14);
      rd(CSR_ADDR);
      chk(d[B_RECEIVE_CHAR_READY], 1);
      pulse(13);
      rd(CSR_ADDR);
      chk(d[B_RECEIVE_CHAR_READY], 0);
      base = 15'h0100;
      pulse(14);
      rd(CSR_ADDR);
      chk(d[B_RECEIVE_CHAR_READY], 0);
      base = 15'h1100;
      eng_i <= base;
      rd(CSR_ADDR);
      chk(d[B_RECEIVE_CHAR_READY], 1);
      for (int k = 0; k < 4; k++) begin
         eng_i <= txe[k];
         rd(CSR_ADDR);
         chk({d[B_TRANSMITTER_DRAINED], d[B_TRANSMIT_HOLDING_FREE]}, txo[k]);
      end
      dma_i <= 4'hA;
      rd(CSR_ADDR);
      chk({d[12:11], d[4:3]}, 4'h5);
      dma_i <= 4'h5;
      rd(CSR_ADDR);
      chk({d[12:11], d[4:3]}, 4'hA);
      tgl <= 4'h9;
      @(posedge clk_i);
      tgl <= 4'h0;
      repeat (6) @(posedge clk_i);
      rd(CSR_ADDR);
      chk(d[23:16], 8'h99);
      rd(CSR_ADDR);
      chk(d[23:16], 8'h90);
      end_of_test;
   end
endmodule
